//--- src/pcgbc_top.sv
// apb register slice: peripheral clock gates and backup domain clock control
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
module pcgbc_top
    import pcgbc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic backup_access_enable,
    input wire logic backup_domain_por,
    input wire logic slow_external_osc,
    input wire logic slow_xtal_stable,
    output logic converter_clk_gate,
    output logic power_if_clk_gate,
    output logic backup_if_clk_gate,
    output logic can_clk_gate,
    output logic usb_device_clk_gate,
    output logic i2c_second_clk_gate,
    output logic i2c_first_clk_gate,
    output logic serial_third_clk_gate,
    output logic serial_second_clk_gate,
    output logic spi_second_clk_gate,
    output logic window_dog_clk_gate,
    output logic timer_four_clk_gate,
    output logic timer_three_clk_gate,
    output logic timer_two_clk_gate,
    output logic backup_domain_soft_reset,
    output logic slow_xtal_enable,
    output logic slow_xtal_bypass,
    output logic [1:0] rtc_source_select,
    output logic rtc_clock_enable
);

////////////////////////////////////////////////////////////////////////////////
// apb slave, one wait-free access phase with registered answers

logic [DATA_W-1:0] prdata_reg, prdata_next;
logic pready_reg, pready_next;
logic pslverr_reg, pslverr_next;
logic [DATA_W-1:0] gates_reg, gates_next;
logic soft_rst_reg, soft_rst_next;
logic xon_reg, xon_next;
logic byp_reg, byp_next;
logic [1:0] sel_reg, sel_next;
logic rtc_clock_enable_reg, rtc_clock_enable_next;
logic lock_reg, lock_next;
logic rdy_reg, rdy_next;
logic [2:0] cnt_reg, cnt_next;
logic lse_s1, lse_s2, lse_s3;
logic stb_s1, stb_s2;
logic setup, hit_gates, hit_bd, wr_gates, wr_bd, bd_rst, lse_edge;
logic [DATA_W-1:0] bd_view;

assign setup = psel & ~penable;
assign hit_gates = (paddr == GATES_OFFSET);
assign hit_bd = (paddr == BDCTL_OFFSET);
assign wr_gates = psel & penable & pready_reg & pwrite & hit_gates;
assign wr_bd = psel & penable & pready_reg & pwrite & hit_bd;

always_comb begin
    bd_view = '0;
    bd_view[BACKUP_DOMAIN_SOFT_RESET_POS] = soft_rst_reg;
    bd_view[RTC_CLOCK_ENABLE_POS] = rtc_clock_enable_reg;
    bd_view[RTC_SOURCE_SELECT_POS +: 2] = sel_reg;
    bd_view[BYP_POS] = byp_reg;
    bd_view[RDY_POS] = rdy_reg;
    bd_view[XON_POS] = xon_reg;
end

always_comb begin
    pready_next = setup;
    pslverr_next = setup & ~hit_gates & ~hit_bd;
    prdata_next = '0;
    if (setup & ~pwrite) begin
        if (hit_gates) begin
            prdata_next = gates_reg;
        end else if (hit_bd) begin
            prdata_next = bd_view;
        end
    end
end

always_ff @(posedge mclk) begin
    if (reset) begin
        prdata_reg <= '0;
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
    end else begin
        prdata_reg <= prdata_next;
        pready_reg <= pready_next;
        pslverr_reg <= pslverr_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// peripheral clock gates and backup soft reset, system reset domain

always_comb begin
    gates_next = gates_reg;
    soft_rst_next = soft_rst_reg;
    if (wr_gates) begin
        // enables move only on mclk, meant for a latch-based gate cell
        gates_next = pwdata & GATES_WMASK;
    end
    if (wr_bd) begin
        soft_rst_next = pwdata[BACKUP_DOMAIN_SOFT_RESET_POS];
    end
end

always_ff @(posedge mclk) begin
    if (reset) begin
        gates_reg <= GATES_RESET;
        soft_rst_reg <= 1'b0;
    end else begin
        gates_reg <= gates_next;
        soft_rst_reg <= soft_rst_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// slow oscillator inputs, two-stage synchronisers

assign lse_edge = lse_s2 & ~lse_s3;

always_ff @(posedge mclk) begin
    lse_s1 <= slow_external_osc;
    lse_s2 <= lse_s1;
    lse_s3 <= lse_s2;
    stb_s1 <= slow_xtal_stable;
    stb_s2 <= stb_s1;
end

////////////////////////////////////////////////////////////////////////////////
// backup domain bits, untouched by system reset

assign bd_rst = soft_rst_reg | backup_domain_por;

always_comb begin
    xon_next = xon_reg;
    byp_next = byp_reg;
    sel_next = sel_reg;
    rtc_clock_enable_next = rtc_clock_enable_reg;
    lock_next = lock_reg | rtc_clock_enable_reg;
    rdy_next = rdy_reg;
    cnt_next = cnt_reg;
    if (wr_bd && backup_access_enable) begin
        xon_next = pwdata[XON_POS];
        if (!xon_reg) begin
            byp_next = pwdata[BYP_POS];
        end
        if (!lock_next) begin
            sel_next = pwdata[RTC_SOURCE_SELECT_POS +: 2];
        end
        rtc_clock_enable_next = pwdata[RTC_CLOCK_ENABLE_POS];
    end
    if (sel_next == PCGBC_SRC_NONE) begin
        rtc_clock_enable_next = 1'b0;
    end
    if (xon_reg) begin
        cnt_next = '0;
        rdy_next = stb_s2;
    end else if (rdy_reg && lse_edge) begin
        // the oscillator winds down on its own clock, so count its edges
        if (cnt_reg == 3'(LSE_CLR_CYCLES - 1)) begin
            rdy_next = 1'b0;
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 3'h1;
        end
    end
end

// system reset deliberately absent here
always_ff @(posedge mclk) begin
    if (bd_rst) begin
        xon_reg <= 1'b0;
        byp_reg <= 1'b0;
        sel_reg <= PCGBC_SRC_NONE;
        rtc_clock_enable_reg <= 1'b0;
        lock_reg <= 1'b0;
        rdy_reg <= 1'b0;
        cnt_reg <= '0;
    end else begin
        xon_reg <= xon_next;
        byp_reg <= byp_next;
        sel_reg <= sel_next;
        rtc_clock_enable_reg <= rtc_clock_enable_next;
        lock_reg <= lock_next;
        rdy_reg <= rdy_next;
        cnt_reg <= cnt_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;
assign converter_clk_gate = gates_reg[CONV_POS];
assign power_if_clk_gate = gates_reg[PWR_POS];
assign backup_if_clk_gate = gates_reg[BKP_POS];
assign can_clk_gate = gates_reg[CAN_POS];
assign usb_device_clk_gate = gates_reg[USBD_POS];
assign i2c_second_clk_gate = gates_reg[I2C2_POS];
assign i2c_first_clk_gate = gates_reg[I2C1_POS];
assign serial_third_clk_gate = gates_reg[SER3_POS];
assign serial_second_clk_gate = gates_reg[SER2_POS];
assign spi_second_clk_gate = gates_reg[SPI2_POS];
assign window_dog_clk_gate = gates_reg[WDOG_POS];
assign timer_four_clk_gate = gates_reg[TIM4_POS];
assign timer_three_clk_gate = gates_reg[TIM3_POS];
assign timer_two_clk_gate = gates_reg[TIM2_POS];
assign backup_domain_soft_reset = soft_rst_reg;
assign slow_xtal_enable = xon_reg;
assign slow_xtal_bypass = byp_reg;
assign rtc_source_select = sel_reg;
assign rtc_clock_enable = rtc_clock_enable_reg;

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge mclk); endclocking
default disable iff (reset);

chk_gate_high_group: assert property (wr_gates |=> gates_reg[29:27] == $past(pwdata[29:27]))
    else $error("high gate group did not follow write");
chk_gate_mid_group: assert property (wr_gates |=> {gates_reg[25], gates_reg[23:21], gates_reg[18:17]}
    == $past({pwdata[25], pwdata[23:21], pwdata[18:17]}))
    else $error("middle gate group did not follow write");
chk_gate_low_group: assert property (wr_gates |=> {gates_reg[14], gates_reg[11], gates_reg[2:0]}
    == $past({pwdata[14], pwdata[11], pwdata[2:0]}))
    else $error("low gate group did not follow write");
chk_reserved_zero: assert property (wr_gates |=> (gates_reg & ~GATES_WMASK) == '0)
    else $error("reserved gate bits not zero");
chk_soft_reset: assert property (soft_rst_reg |=> !xon_reg && !byp_reg && !rtc_clock_enable_reg && !rdy_reg)
    else $error("backup soft reset did not clear domain");
chk_sel_default: assert property (soft_rst_reg |=> sel_reg == PCGBC_SRC_NONE)
    else $error("source select not restored by backup reset");
chk_rtc_clock_enable_forced: assert property (rtc_clock_enable_reg |-> sel_reg != PCGBC_SRC_NONE)
    else $error("rtc enabled without a source");
chk_sel_frozen: assert property (lock_reg && !bd_rst |=> $stable(sel_reg))
    else $error("source select changed while locked");
chk_bypass_guard: assert property (xon_reg && !bd_rst |=> $stable(byp_reg))
    else $error("bypass changed while oscillator enabled");
chk_protect: assert property (!backup_access_enable && !bd_rst |=> $stable({xon_reg, byp_reg, sel_reg, rtc_clock_enable_reg}))
    else $error("protected backup bit changed");
chk_ready_cause: assert property ($rose(rdy_reg) |-> $past(xon_reg) && $past(stb_s2))
    else $error("ready rose without a stable oscillator");
chk_ready_clear: assert property (!xon_reg && rdy_reg && lse_edge && cnt_reg == 3'h5 && !bd_rst |=> !rdy_reg)
    else $error("ready not cleared after six slow edges");
chk_sysreset_keep: assert property (disable iff (1'b0) reset && !bd_rst |=> $stable({xon_reg, sel_reg, rtc_clock_enable_reg}))
    else $error("system reset disturbed backup bits");

cov_gate_write: cover property (wr_gates ##1 timer_two_clk_gate);
cov_rtc_lock: cover property (rtc_clock_enable_reg ##1 lock_reg ##[1:20] wr_bd);
cov_ready_rise: cover property ($rose(rdy_reg));
cov_ready_fall: cover property ($fell(rdy_reg) && !bd_rst);

endmodule

//--- src/pcgbc_pkg.sv
// shared constants for the peripheral clock gate and backup clock control block
package pcgbc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] GATES_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] BDCTL_OFFSET = 12'h004;
    // clock gate bit positions
    localparam int CONV_POS = 29;
    localparam int PWR_POS = 28;
    localparam int BKP_POS = 27;
    localparam int CAN_POS = 25;
    localparam int USBD_POS = 23;
    localparam int I2C2_POS = 22;
    localparam int I2C1_POS = 21;
    localparam int SER3_POS = 18;
    localparam int SER2_POS = 17;
    localparam int SPI2_POS = 14;
    localparam int WDOG_POS = 11;
    localparam int TIM4_POS = 2;
    localparam int TIM3_POS = 1;
    localparam int TIM2_POS = 0;
    localparam logic [DATA_W-1:0] GATES_WMASK = 32'h3ae6_4807;
    localparam logic [DATA_W-1:0] GATES_RESET = 32'h0000_0000;
    // backup domain control field positions
    localparam int BACKUP_DOMAIN_SOFT_RESET_POS = 16;
    localparam int RTC_CLOCK_ENABLE_POS = 15;
    localparam int RTC_SOURCE_SELECT_POS = 8;
    localparam int BYP_POS = 2;
    localparam int RDY_POS = 1;
    localparam int XON_POS = 0;
    localparam int LSE_CLR_CYCLES = 6;
    localparam int HSE_RTC_DIV = 128;
    typedef enum logic [1:0] {
        PCGBC_SRC_NONE = 2'h0,
        PCGBC_SRC_SLOW_EXT = 2'h1,
        PCGBC_SRC_SLOW_INT = 2'h2,
        PCGBC_SRC_FAST_DIV = 2'h3
    } pcgbc_rtc_src_t;
endpackage

//--- bench/pcgbc_tb_top.sv
// self-checking bench for the clock gate and backup clock control block
`timescale 1ns/100ps
module pcgbc_tb_top
    import pcgbc_pkg::*;
;
    logic mclk, reset, psel, penable, pwrite, backup_access_enable, backup_domain_por;
    logic slow_external_osc, slow_xtal_stable, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic conv, pwr, bkp, can, usb, i2c2, i2c1, ser3, ser2, spi2, wdog, tim4, tim3, tim2;
    logic bd_rst, x_en, x_byp, rtc_en, err;
    logic [1:0] rtc_sel;
    int num_errors = 0;
    int num_checks = 0;
    wire logic [31:0] gate_vec = {2'h0, conv, pwr, bkp, 1'h0, can, 1'h0, usb, i2c2, i2c1, 2'h0, ser3, ser2,
                                  2'h0, spi2, 2'h0, wdog, 8'h00, tim4, tim3, tim2};

    pcgbc_top u_pcgbc_top (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .backup_access_enable(backup_access_enable), .backup_domain_por(backup_domain_por),
        .slow_external_osc(slow_external_osc), .slow_xtal_stable(slow_xtal_stable),
        .converter_clk_gate(conv), .power_if_clk_gate(pwr), .backup_if_clk_gate(bkp), .can_clk_gate(can),
        .usb_device_clk_gate(usb), .i2c_second_clk_gate(i2c2), .i2c_first_clk_gate(i2c1),
        .serial_third_clk_gate(ser3), .serial_second_clk_gate(ser2), .spi_second_clk_gate(spi2),
        .window_dog_clk_gate(wdog), .timer_four_clk_gate(tim4), .timer_three_clk_gate(tim3),
        .timer_two_clk_gate(tim2), .backup_domain_soft_reset(bd_rst), .slow_xtal_enable(x_en),
        .slow_xtal_bypass(x_byp), .rtc_source_select(rtc_sel), .rtc_clock_enable(rtc_en));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until pready is sampled high at a rising edge, released at that edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        if (n == 20) check("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a write lands at the access edge, so pins settle one edge later
        if (wr) @(posedge mclk);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_gates();
        logic [31:0] pats [3];
        pats = '{32'hffff_ffff, 32'h5555_5555, 32'haaaa_aaaa};
        apb(1'b0, GATES_OFFSET, 32'h0);
        check("gates reset", rd, GATES_RESET);
        foreach (pats[i]) begin
            apb(1'b1, GATES_OFFSET, pats[i]);
            apb(1'b0, GATES_OFFSET, 32'h0);
            check("gates read", rd, pats[i] & 32'h3ae6_4807);
            check("gate pins", gate_vec, pats[i] & 32'h3ae6_4807);
        end
        apb(1'b0, 12'h0f0, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask

    task automatic test_xtal();
        apb(1'b0, BDCTL_OFFSET, 32'h0);
        check("bdctl reset", rd, 32'h0);
        backup_access_enable <= 1'b0;
        apb(1'b1, BDCTL_OFFSET, 32'h0000_0005);
        check("protected", {30'h0, x_byp, x_en}, 32'h0);
        apb(1'b1, GATES_OFFSET, 32'h1800_0000);
        check("access clocks", {30'h0, pwr, bkp}, 32'h3);
        backup_access_enable <= 1'b1;
        apb(1'b1, BDCTL_OFFSET, 32'h0000_0005);
        check("enable bypass", {30'h0, x_byp, x_en}, 32'h3);
        apb(1'b1, BDCTL_OFFSET, 32'h0000_0001);
        check("bypass locked", {31'h0, x_byp}, 32'h1);
        repeat (10) @(posedge mclk);
        apb(1'b0, BDCTL_OFFSET, 32'h0);
        check("not ready", rd, 32'h0000_0005);
        slow_xtal_stable <= 1'b1;
        repeat (10) @(posedge mclk);
        apb(1'b0, BDCTL_OFFSET, 32'h0);
        check("ready", rd, 32'h0000_0007);
        apb(1'b1, BDCTL_OFFSET, 32'h0);
        repeat (5) slow_edge();
        repeat (3) @(posedge mclk);
        apb(1'b0, BDCTL_OFFSET, 32'h0);
        check("ready held", rd, 32'h0000_0006);
        slow_edge();
        repeat (6) @(posedge mclk);
        apb(1'b0, BDCTL_OFFSET, 32'h0);
        check("ready cleared", rd, 32'h0000_0004);
    endtask

    task automatic slow_edge();
        repeat (4) @(posedge mclk);
        slow_external_osc <= 1'b1;
        repeat (4) @(posedge mclk);
        slow_external_osc <= 1'b0;
    endtask

    task automatic test_rtc();
        logic [1:0] other;
        apb(1'b1, BDCTL_OFFSET, 32'h0000_8000);
        check("rtc en no source", {31'h0, rtc_en}, 32'h0);
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, BDCTL_OFFSET, 32'h0001_0000);
            check("soft reset pin", {31'h0, bd_rst}, 32'h1);
            apb(1'b0, BDCTL_OFFSET, 32'h0);
            check("soft reset clears", rd, 32'h0001_0000);
            apb(1'b1, BDCTL_OFFSET, 32'h0);
            apb(1'b1, BDCTL_OFFSET, 32'h0000_8000 | (32'(c) << 8));
            check("select", {30'h0, rtc_sel}, 32'(c));
            check("rtc en", {31'h0, rtc_en}, 32'h1);
            other = 2'(c) + 2'h1;
            apb(1'b1, BDCTL_OFFSET, 32'h0000_8000 | (32'(other) << 8));
            apb(1'b0, BDCTL_OFFSET, 32'h0);
            check("select locked", rd, 32'h0000_8000 | (32'(c) << 8));
        end
        apb(1'b1, GATES_OFFSET, 32'h1800_0000);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, BDCTL_OFFSET, 32'h0);
        check("sys reset keeps", rd, 32'h0000_8300);
        check("sys reset gates", gate_vec, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        backup_domain_por = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        backup_access_enable = 1'b0;
        slow_external_osc = 1'b0;
        slow_xtal_stable = 1'b0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        backup_domain_por <= 1'b0;
        test_gates();
        test_xtal();
        test_rtc();
        print_verdict();
    end

    // run needs about 220 cycles; 15000 cycles, well over sixty times that, is a hang
    initial begin
        repeat (15000) @(posedge mclk);
        num_errors++;
        print_verdict();
    end
endmodule
